//--- hw/psbsc_pkg.sv
package psbsc_pkg;
   // ==========================================================
   // Geometry
   localparam int ADDR_W = 21;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int DATA_W = LANES * LANE_W;
   localparam int DEPTH = 2 ** ADDR_W;
   localparam int BURST_W = 2;
   // ==========================================================
   // Reset values, burst step and lane masks
   localparam logic [BURST_W-1:0] COUNT_RST = 2'h0;
   localparam logic [BURST_W-1:0] COUNT_STEP = 2'h1;
   localparam logic ORDER_RST = 1'h1;
   localparam logic [LANES-1:0] LANES_ALL = 4'hf;
   localparam logic [LANES-1:0] LANES_NONE = 4'h0;
   // ==========================================================
   // Port state
   typedef enum logic [1:0] {
      ST_DESELECT = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_SLEEP = 2'b10
   } psbsc_state_t;
   typedef struct packed {
      psbsc_state_t state;
      logic [ADDR_W-1:0] addr;
      logic [BURST_W-1:0] start_bits;
      logic [BURST_W-1:0] count;
      logic rd_pending;
      logic drive;
      logic interleave;
   } psbsc_regs_t;
endpackage

//--- hw/psbsc_mem_if.sv
`timescale 1ns/10ps
// Array access signals between control port and storage
interface psbsc_mem_if;
   import psbsc_pkg::*;
   logic wr_en;
   logic [LANES-1:0] wr_lanes;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic rd_en;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   modport ctrl (output wr_en, wr_lanes, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
   modport mem (input wr_en, wr_lanes, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

//--- hw/psbsc_mem.sv
`timescale 1ns/10ps
module psbsc_mem (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Array port
   psbsc_mem_if.mem mem
);
   import psbsc_pkg::*;
   // ==========================================================
   // One storage column per byte lane, registered read
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         logic [LANE_W-1:0] cells [0:DEPTH-1];
         logic [LANE_W-1:0] rd_reg;
         // Lane write and read
         always_ff @(posedge i_clk) begin
            if (mem.wr_en && mem.wr_lanes[g]) begin
               cells[mem.wr_addr] <= mem.wr_data[g*LANE_W +: LANE_W];
            end
            if (!i_rst_n) begin
               rd_reg <= '0;
            end else if (mem.rd_en) begin
               rd_reg <= cells[mem.rd_addr];
            end
         end
         assign mem.rd_data[g*LANE_W +: LANE_W] = rd_reg;
      end
   endgenerate
endmodule

//--- hw/psbsc_top.sv
`timescale 1ns/10ps
module psbsc_top (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Address and selects
   input wire logic [psbsc_pkg::ADDR_W-1:0] i_addr,
   input wire logic i_chip_select_primary_n,
   input wire logic i_chip_select_expand_hi,
   input wire logic i_chip_select_expand_n,
   // Burst control
   input wire logic i_processor_addr_strobe_n,
   input wire logic i_controller_addr_strobe_n,
   input wire logic i_burst_advance_n,
   input wire logic i_burst_order,
   // Write control
   input wire logic i_global_write_n,
   input wire logic i_byte_write_enable_n,
   input wire logic [psbsc_pkg::LANES-1:0] i_byte_lane_select_n,
   // Data pins, lane bit 8 is the parity pin
   input wire logic [psbsc_pkg::DATA_W-1:0] i_dq,
   output logic [psbsc_pkg::DATA_W-1:0] o_dq,
   output logic o_dq_oe,
   // Output enable and sleep
   input wire logic i_output_enable_n,
   input wire logic i_sleep_request,
   output logic o_sleeping
);
   import psbsc_pkg::*;

   psbsc_regs_t r_reg;
   psbsc_regs_t r_next;
   logic sel_w;
   logic proc_w;
   logic load_w;
   logic go_w;
   logic wr_any_w;
   logic [LANES-1:0] lanes_w;
   logic [BURST_W-1:0] seq_w;

   psbsc_mem_if mif ();

   // ==========================================================
   // Storage
   psbsc_mem u_mem (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .mem(mif.mem)
   );

   // ==========================================================
   // Input decode
   always_comb begin
      sel_w = !i_chip_select_primary_n && i_chip_select_expand_hi
              && !i_chip_select_expand_n;
      proc_w = !i_processor_addr_strobe_n && !i_chip_select_primary_n;
      load_w = proc_w || !i_controller_addr_strobe_n;
      wr_any_w = !i_global_write_n || !i_byte_write_enable_n;
      if (!i_global_write_n) begin
         lanes_w = LANES_ALL;
      end else if (!i_byte_write_enable_n) begin
         lanes_w = ~i_byte_lane_select_n;
      end else begin
         lanes_w = LANES_NONE;
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      r_next = r_reg;
      go_w = 1'b0;
      seq_w = r_reg.start_bits;
      r_next.interleave = i_burst_order;
      r_next.drive = r_reg.rd_pending && !i_sleep_request;
      if (i_sleep_request) begin
         // Parked, array untouched
         r_next.state = ST_SLEEP;
         r_next.rd_pending = 1'b0;
      end else if (load_w) begin
         if (sel_w) begin
            r_next.state = ST_ACTIVE;
            r_next.addr = i_addr;
            r_next.start_bits = i_addr[BURST_W-1:0];
            r_next.count = COUNT_RST;
            go_w = 1'b1;
         end else begin
            r_next.state = ST_DESELECT;
         end
      end else if (r_reg.state == ST_ACTIVE) begin
         // Selects not looked at here
         go_w = 1'b1;
         if (!i_burst_advance_n) begin
            r_next.count = r_reg.count + COUNT_STEP;
         end
         if (r_reg.interleave) begin
            seq_w = r_reg.start_bits ^ r_next.count;
         end else begin
            seq_w = r_reg.start_bits + r_next.count;
         end
         r_next.addr[BURST_W-1:0] = seq_w;
      end else begin
         r_next.state = ST_DESELECT;
      end
      if (!i_sleep_request) begin
         r_next.rd_pending = go_w && !wr_any_w;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         r_reg <= '{state: ST_DESELECT, addr: '0, start_bits: COUNT_RST, count: COUNT_RST,
                    rd_pending: 1'b0, drive: 1'b0, interleave: ORDER_RST};
      end else begin
         r_reg <= r_next;
      end
   end

   // ==========================================================
   // Array access, self-timed write at the capturing edge
   assign mif.wr_en = go_w && wr_any_w && !i_sleep_request;
   assign mif.wr_lanes = lanes_w;
   assign mif.wr_addr = r_next.addr;
   assign mif.wr_data = i_dq;
   assign mif.rd_en = r_reg.rd_pending;
   assign mif.rd_addr = r_reg.addr;

   // ==========================================================
   // Outputs; output enable acts without the clock
   assign o_dq = mif.rd_data;
   assign o_dq_oe = r_reg.drive && !i_output_enable_n;
   assign o_sleeping = r_reg.state[1]; // Only the sleep code has this bit set

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_sel_load;
      load_w && sel_w && !i_sleep_request;
   endsequence
   sequence s_read_start;
      go_w && !wr_any_w && !i_sleep_request;
   endsequence

   addr_capture_a: assert property (s_sel_load |=> r_reg.addr == $past(i_addr))
      else $error("address not captured on selected load");
   proc_ignore_a: assert property ((i_chip_select_primary_n && !i_processor_addr_strobe_n
      && i_controller_addr_strobe_n && !i_sleep_request && r_reg.state == ST_DESELECT)
      |=> r_reg.state == ST_DESELECT)
      else $error("processor strobe not ignored");
   proc_priority_a: assert property ((proc_w && !i_controller_addr_strobe_n && sel_w
      && !i_sleep_request) |=> r_reg.count == COUNT_RST
      && r_reg.start_bits == $past(i_addr[BURST_W-1:0]))
      else $error("both strobes did not load once");
   burst_adv_a: assert property ((r_reg.state == ST_ACTIVE && !load_w && !i_burst_advance_n
      && !i_sleep_request) |=> r_reg.count == $past(r_reg.count) + COUNT_STEP)
      else $error("burst counter did not advance");
   seq_map_a: assert property (r_reg.state == ST_ACTIVE |-> r_reg.addr[BURST_W-1:0] ==
      (r_reg.interleave ? (r_reg.start_bits ^ r_reg.count)
                        : (r_reg.start_bits + r_reg.count)))
      else $error("burst address sequence wrong");
   sel_hold_a: assert property ((r_reg.state == ST_ACTIVE && !load_w && !i_sleep_request)
      |=> r_reg.state == ST_ACTIVE)
      else $error("selects sampled during burst");
   deselect_a: assert property ((load_w && !sel_w && !i_sleep_request)
      |=> r_reg.state == ST_DESELECT && !r_reg.rd_pending ##1 !r_reg.drive)
      else $error("deselect not taken");
   global_write_a: assert property ((go_w && !i_global_write_n && !i_sleep_request)
      |-> mif.wr_en && mif.wr_lanes == LANES_ALL)
      else $error("global write missed a lane");
   byte_write_a: assert property ((go_w && i_global_write_n && !i_byte_write_enable_n
      && !i_sleep_request) |-> mif.wr_lanes == ~i_byte_lane_select_n)
      else $error("byte lanes not as selected");
   read_pipe_a: assert property (s_read_start ##1 !i_sleep_request
      |-> mif.rd_en && mif.rd_addr == $past(r_next.addr) ##1 r_reg.drive)
      else $error("read data not one edge after address");
   first_mask_a: assert property ((s_read_start ##0 r_reg.state == ST_DESELECT)
      |=> !o_dq_oe)
      else $error("outputs driven in first read clock");
   sleep_quiet_a: assert property (i_sleep_request |-> !mif.wr_en
      ##1 o_sleeping && !r_reg.rd_pending)
      else $error("sleep not quiet");
endmodule

//--- tb/psbsc_host.sv
`timescale 1ns/10ps
// ==========
// Controller model facing the control port
module psbsc_host (
   // Clock
   input wire logic i_clk,
   // Port drive
   output logic [psbsc_pkg::ADDR_W-1:0] o_addr,
   output logic [2:0] o_sel,
   output logic o_sp_n,
   output logic o_sc_n,
   output logic o_adv_n,
   output logic o_order,
   output logic o_gw_n,
   output logic o_bwe_n,
   output logic [psbsc_pkg::LANES-1:0] o_ln_n,
   output logic [psbsc_pkg::DATA_W-1:0] o_dq,
   output logic o_oe_n,
   output logic o_sleep
);
   import psbsc_pkg::*;
   // Idle levels from time zero
   initial begin
      {o_sp_n, o_sc_n, o_adv_n, o_gw_n, o_bwe_n} = 5'h1f;
      {o_addr, o_sel, o_ln_n, o_dq} = '0;
      {o_order, o_oe_n, o_sleep} = 3'h0;
   end
   // One bus cycle launched at the falling edge
   task automatic cyc(input logic [1:0] st_n, input logic [2:0] sel, input logic [1:0] wr_n,
         input logic [LANES-1:0] ln_n, input logic adv_n, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d);
      @(negedge i_clk);
      {o_sp_n, o_sc_n} = st_n;
      {o_gw_n, o_bwe_n} = wr_n;
      o_sel = sel;
      o_ln_n = ln_n;
      o_adv_n = adv_n;
      o_addr = a;
      o_dq = (&wr_n) ? ~o_dq : d; // Junk data when no write is meant
   endtask
endmodule

//--- tb/psbsc_top_tb.sv
`timescale 1ns/10ps
// ==========
// Self-checking bench for the control port
module psbsc_top_tb;
   import psbsc_pkg::*;
   localparam logic [2:0] SEL = 3'h2;
   localparam logic [ADDR_W-1:0] BASE = 21'h1a5b4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [DATA_W-1:0] model [int];
   logic [ADDR_W-1:0] addr;
   logic [2:0] sel;
   logic sp_n, sc_n, adv_n, order, gw_n, bwe_n, oe_n, sleep, dq_oe, sleeping;
   logic [LANES-1:0] ln_n;
   logic [DATA_W-1:0] dq_in, dq_out;
   // Far side and device
   psbsc_host i_host (.i_clk(clk), .o_addr(addr), .o_sel(sel), .o_sp_n(sp_n), .o_sc_n(sc_n),
      .o_adv_n(adv_n), .o_order(order), .o_gw_n(gw_n), .o_bwe_n(bwe_n), .o_ln_n(ln_n),
      .o_dq(dq_in), .o_oe_n(oe_n), .o_sleep(sleep));
   psbsc_top i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
      .i_chip_select_primary_n(sel[2]), .i_chip_select_expand_hi(sel[1]),
      .i_chip_select_expand_n(sel[0]), .i_processor_addr_strobe_n(sp_n),
      .i_controller_addr_strobe_n(sc_n), .i_burst_advance_n(adv_n), .i_burst_order(order),
      .i_global_write_n(gw_n), .i_byte_write_enable_n(bwe_n), .i_byte_lane_select_n(ln_n),
      .i_dq(dq_in), .o_dq(dq_out), .o_dq_oe(dq_oe), .i_output_enable_n(oe_n),
      .i_sleep_request(sleep), .o_sleeping(sleeping));
   // Clock and hang guard
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         close_out();
      end
   end
   // Result comparisons
   task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: data %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask
   // Write cycle; reference copy changes only where the port takes it
   task automatic wr(input logic [1:0] st_n, input logic [2:0] s, input logic [1:0] wr_n,
         input logic [LANES-1:0] ln, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
         input logic hits);
      logic [DATA_W-1:0] m;
      m = model.exists(a) ? model[a] : '0;
      i_host.cyc(st_n, s, wr_n, ln, 1'b1, a, d);
      for (int k = 0; k < LANES; k++)
         if (!wr_n[1] || (!wr_n[0] && !ln[k])) m[k*LANE_W +: LANE_W] = d[k*LANE_W +: LANE_W];
      if (hits) model[a] = m;
   endtask
   // Strobed read of n words, selects held wrong while advancing, then deselect
   task automatic rd(input logic [1:0] st_n, input logic [ADDR_W-1:0] a, input int n);
      logic [ADDR_W-1:0] x;
      i_host.cyc(st_n, SEL, 2'h3, 4'h0, 1'b1, a, '0);
      for (int k = 0; k <= n; k++) begin
         i_host.cyc(2'h3, 3'h5, 2'h3, 4'h0, 1'b0, a, '0);
         if (k == 0) chk_flag(dq_oe, 1'b0);
         else begin
            x = a;
            x[1:0] = order ? (a[1:0] ^ 2'(k - 1)) : (a[1:0] + 2'(k - 1));
            chk_word(dq_out, model[x]);
            chk_flag(dq_oe, !oe_n);
         end
      end
      i_host.cyc(2'h2, 3'h6, 2'h3, 4'h0, 1'b1, a, '0);
      i_host.cyc(2'h3, SEL, 2'h3, 4'h0, 1'b1, a, '0);
   endtask
   // Linear then interleaved bursts from a mid-line start
   task automatic scn_bursts();
      for (int o = 0; o < 2; o++) begin
         i_host.o_order = 1'(o);
         for (int i = 0; i < 4; i++)
            wr(2'h1, SEL, 2'h1, 4'h0, BASE + 21'(i), 36'h123456789 ^ {4{9'(i + 4 * o)}}, 1'b1);
         rd(o ? 2'h2 : 2'h1, BASE + 21'h2, 4);
      end
   endtask
   // Lane writes, read cycles and refused accesses
   task automatic scn_lanes_sel();
      wr(2'h2, SEL, 2'h2, 4'ha, BASE, 36'h955555555, 1'b1);
      wr(2'h1, SEL, 2'h3, 4'h0, BASE + 21'h1, '0, 1'b1);
      wr(2'h1, SEL, 2'h2, 4'hf, BASE + 21'h2, '0, 1'b1);
      wr(2'h1, 3'h0, 2'h1, 4'h0, BASE + 21'h3, '1, 1'b0);
      wr(2'h1, 3'h3, 2'h1, 4'h0, BASE + 21'h3, '1, 1'b0);
      wr(2'h1, 3'h6, 2'h1, 4'h0, BASE + 21'h3, '1, 1'b0);
      rd(2'h1, BASE, 4);
      wr(2'h0, SEL, 2'h1, 4'h0, BASE + 21'h3, 36'h0c3c3c3c3, 1'b1);
      rd(2'h2, BASE + 21'h3, 1);
   endtask
   // Output enable release and sleep parking
   task automatic scn_oe_sleep();
      i_host.o_oe_n = 1'b1;
      rd(2'h1, BASE + 21'h3, 2);
      i_host.o_oe_n = 1'b0;
      i_host.o_sleep = 1'b1;
      wr(2'h1, SEL, 2'h1, 4'h0, BASE + 21'h3, '0, 1'b0);
      i_host.cyc(2'h3, SEL, 2'h3, 4'h0, 1'b1, BASE, '0);
      chk_flag(sleeping, 1'b1);
      chk_flag(dq_oe, 1'b0);
      i_host.o_sleep = 1'b0;
      i_host.cyc(2'h3, SEL, 2'h3, 4'h0, 1'b1, BASE, '0);
      chk_flag(sleeping, 1'b0);
      rd(2'h1, BASE + 21'h3, 1);
   endtask
   // Verdict and end of run
   task automatic close_out();
      $display("Comparisons %0d, errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      scn_bursts();
      scn_lanes_sel();
      scn_oe_sleep();
      close_out();
   end
endmodule
